/* core/msp_edge_det.sv */
// Falling-edge detector with a two-stage pin synchroniser.
`timescale 1ns/100ps

module msp_edge_det (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Pin input, active low, pulled up.
  input wire logic req_n,
  // One-cycle pulse on each high-to-low transition.
  output logic fall
);

  // ----------------------------------------------------------------
  // Synchroniser and history
  // ----------------------------------------------------------------
  // Stages reset high because the line idles high through its pull-up.
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Only s2_q reads s1_q; the edge logic looks at s2_q and s3_q.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else if (clk_en) begin
      s1_q <= req_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A low level holding still gives no further pulses.
  assign fall = clk_en && s3_q && !s2_q;

endmodule

/* core/msp_pkg.sv */
// Package of constants shared by the module site parallel port.
package msp_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int MSP_AW = 6;
  localparam int MSP_DW = 8;
  localparam int MSP_HAW = 32;
  localparam int MSP_HDW = 32;

  // ----------------------------------------------------------------
  // Address fields of the processor bus
  // ----------------------------------------------------------------
  // Low address bit of the module address on the older variant.
  localparam int MSP_ADDR_LSB_OLD = 2;
  // Low address bit of the module address on the newer variant.
  localparam int MSP_ADDR_LSB_NEW = 1;
  // Mask and base of the module sub-range inside chip-enable space 3.
  localparam logic [MSP_HAW-1:0] MSP_SUB_MASK = 32'hFFFF_FF00;
  localparam logic [MSP_HAW-1:0] MSP_SUB_BASE = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Interrupt routing
  // ----------------------------------------------------------------
  // Number of module interrupt request inputs.
  localparam int MSP_NIRQ = 3;
  // Number of processor interrupt targets: external 4..7 and the NMI.
  localparam int MSP_NTGT = 5;
  // Route codes, three bits each.
  localparam logic [2:0] MSP_RT_EXT4 = 3'h0;
  localparam logic [2:0] MSP_RT_NMI = 3'h4;

  // ----------------------------------------------------------------
  // Transfer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MSP_IDLE,
    MSP_WAIT,
    MSP_DONE
  } msp_state_t;

endpackage

/* core/msp_port.sv */
// Module site parallel port: strobed bus cycle, module resets, irq routing.
`timescale 1ns/100ps

module msp_port
  import msp_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Board variant: high selects the newer processor and board.
  input wire logic new_variant,
  // Processor request side, same clock domain.
  input wire logic cpu_req,
  input wire logic cpu_ce3,
  input wire logic cpu_we,
  input wire logic [MSP_HAW-1:0] cpu_addr,
  input wire logic [MSP_DW-1:0] cpu_wdata,
  output logic cpu_ack,
  output logic cpu_busy,
  output logic [MSP_DW-1:0] cpu_rdata,
  // Module parallel bus pins.
  output logic [MSP_AW-1:0] module_addr,
  input wire logic [MSP_DW-1:0] module_data_in,
  output logic [MSP_DW-1:0] module_data_out,
  output logic module_data_oe_n,
  output logic module_xfer_strobe_n,
  output logic module_write_en_n,
  input wire logic module_ready_n,
  // Reset control bits and module reset pins.
  input wire logic site_reset_bit,
  input wire logic extender_reset_bit,
  output logic site_reset_n,
  output logic extender_reset_n,
  // Module interrupt request pins.
  input wire logic dedicated_module_irq0_n,
  input wire logic dedicated_module_irq1_n,
  input wire logic dedicated_module_irq2_n,
  input wire logic pio_site_irq0_n,
  // Interrupt enables and routes, one per request.
  input wire logic [MSP_NIRQ-1:0] irq_enable,
  input wire logic [3*MSP_NIRQ-1:0] irq_route,
  // Processor interrupt pulses: external 4..7 in bits 0..3, NMI in bit 4.
  output logic [MSP_NTGT-1:0] cpu_irq,
  output logic cpu_ext_irq4
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Decodes a route code into a one-hot target; unknown codes go nowhere.
  function automatic logic [MSP_NTGT-1:0] route_dec(input logic [2:0] code);
    logic [MSP_NTGT-1:0] r;
    r = '0;
    if (code <= MSP_RT_NMI) begin
      r[code] = 1'b1;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers for ready
  // ----------------------------------------------------------------
  // Ready comes from the module's own timing, so it is synchronised.
  logic rdy1_q;
  logic rdy2_q;
  // Data is sampled in the same cycle ready is seen, through two stages too.
  logic [MSP_DW-1:0] din1_q;
  logic [MSP_DW-1:0] din2_q;

  // Reset to high models the pull-up when nothing drives ready.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdy1_q <= 1'b1;
      rdy2_q <= 1'b1;
      din1_q <= '0;
      din2_q <= '0;
    end else if (clk_en) begin
      rdy1_q <= module_ready_n;
      rdy2_q <= rdy1_q;
      din1_q <= module_data_in;
      din2_q <= din1_q;
    end
  end

  // ----------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------
  msp_state_t state_q;
  // Access decode of the current request.
  logic hit;
  assign hit = cpu_req && cpu_ce3 && ((cpu_addr & MSP_SUB_MASK) == MSP_SUB_BASE);
  // A new cycle opens only once ready from the last one is seen released.
  // Otherwise the low level still in the synchroniser would end it at once.
  logic take;
  assign take = hit && rdy2_q;

  // Strobe waits for ready low; an absent module stalls the cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= MSP_IDLE;
    end else if (clk_en) begin
      case (state_q)
        MSP_IDLE: begin
          if (take) begin
            state_q <= MSP_WAIT;
          end
        end
        MSP_WAIT: begin
          if (!rdy2_q) begin
            state_q <= MSP_DONE;
          end
        end
        MSP_DONE: begin
          // Strobe releases here, one cycle after ready was sampled low.
          state_q <= MSP_IDLE;
        end
        default: begin
          state_q <= MSP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address, data and control registers
  // ----------------------------------------------------------------
  // Address and data load only when a cycle opens and the controls release in DONE, so all hold still while strobed.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      module_addr <= '0;
      module_data_out <= '0;
      module_write_en_n <= 1'b1;
      module_data_oe_n <= 1'b1;
      module_xfer_strobe_n <= 1'b1;
    end else if (clk_en) begin
      if (state_q == MSP_IDLE && take) begin
        // Newer variant takes A1..A6, older A2..A7.
        if (new_variant) begin
          module_addr <= cpu_addr[MSP_ADDR_LSB_NEW +: MSP_AW];
        end else begin
          module_addr <= cpu_addr[MSP_ADDR_LSB_OLD +: MSP_AW];
        end
        module_data_out <= cpu_wdata;
        module_write_en_n <= !cpu_we;
        module_data_oe_n <= !cpu_we;
        module_xfer_strobe_n <= 1'b0;
      end else if (state_q == MSP_WAIT && !rdy2_q) begin
        // Strobe stays low through the DONE cycle, then releases.
        module_xfer_strobe_n <= 1'b0;
      end else if (state_q == MSP_DONE) begin
        module_xfer_strobe_n <= 1'b1;
        module_write_en_n <= 1'b1;
        module_data_oe_n <= 1'b1;
      end
    end
  end

  // Read data is captured when ready is seen, then answered in DONE.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_rdata <= '0;
    end else if (clk_en && state_q == MSP_WAIT && !rdy2_q) begin
      cpu_rdata <= din2_q;
    end
  end

  assign cpu_ack = clk_en && (state_q == MSP_DONE);
  assign cpu_busy = (state_q != MSP_IDLE);

  // ----------------------------------------------------------------
  // Module reset outputs
  // ----------------------------------------------------------------
  // Registered so the pins are glitch free; asserted during board reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      site_reset_n <= 1'b0;
      extender_reset_n <= 1'b0;
    end else if (clk_en) begin
      site_reset_n <= !site_reset_bit;
      extender_reset_n <= !extender_reset_bit;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  logic [MSP_NIRQ-1:0] req_n;
  logic [MSP_NIRQ-1:0] fall;
  logic [MSP_NTGT-1:0] irq_d;

  // Older board shares request 0 with the parallel I/O site (wired-AND).
  assign req_n[0] = new_variant ? dedicated_module_irq0_n
                                : (dedicated_module_irq0_n & pio_site_irq0_n);
  assign req_n[1] = dedicated_module_irq1_n;
  assign req_n[2] = dedicated_module_irq2_n;

  // One falling-edge detector per request line.
  generate
    for (genvar i = 0; i < MSP_NIRQ; i++) begin : g_irq
      msp_edge_det u_edge (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .req_n(req_n[i]),
        .fall(fall[i])
      );
    end
  endgenerate

  // Routing: request 0 on the older board is fixed to external 4.
  always_comb begin
    irq_d = '0;
    for (int i = 0; i < MSP_NIRQ; i++) begin
      if (fall[i] && irq_enable[i]) begin
        if (i == 0 && !new_variant) begin
          irq_d = irq_d | route_dec(MSP_RT_EXT4);
        end else begin
          irq_d = irq_d | route_dec(irq_route[3*i +: 3]);
        end
      end
    end
  end

  // Pulses are registered, one cycle wide per edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_irq <= '0;
    end else if (clk_en) begin
      cpu_irq <= irq_d;
    end else begin
      cpu_irq <= '0;
    end
  end

  assign cpu_ext_irq4 = cpu_irq[MSP_RT_EXT4];

endmodule

/* testbench/msp_module_model.sv */
// Plug-in module model: byte memory answering the strobe with ready.
`timescale 1ns/100ps
module msp_module_model
  import msp_pkg::*;
(
  // Clock and pins seen from the module; only the bus clock, no serial clock.
  input wire logic clk,
  input wire logic module_xfer_strobe_n,
  input wire logic module_write_en_n,
  input wire logic [MSP_AW-1:0] module_addr,
  input wire logic [MSP_DW-1:0] module_data_out,
  input wire logic [3:0] wait_cycles,
  output logic module_ready_n,
  output logic [MSP_DW-1:0] module_data_in
);
  logic [MSP_DW-1:0] mem_q [64]; // Module memory.
  logic [3:0] cnt_q; // Cycles since strobe fell.
  initial begin
    module_ready_n = 1'b1;
    module_data_in = 8'h5A;
    cnt_q = 4'h0;
    for (int i = 0; i < 64; i++) mem_q[i] = 8'(i) ^ 8'h3C;
  end
  // Ready after the chosen wait, held until the strobe is released.
  always @(posedge clk) begin
    if (!module_xfer_strobe_n) begin
      if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
      if (cnt_q >= wait_cycles) module_ready_n <= 1'b0;
      if (cnt_q == wait_cycles && !module_write_en_n) mem_q[module_addr] <= module_data_out;
    end else begin
      cnt_q <= 4'h0;
      module_ready_n <= 1'b1;
    end
    // Released lines toggle, so a stale byte can never pass as read data.
    if (!module_xfer_strobe_n && module_write_en_n) module_data_in <= mem_q[module_addr];
    else module_data_in <= ~module_data_in;
  end
endmodule

/* testbench/msp_port_checker.sv */
// Timing checks on the module site port, bound to msp_port.
`timescale 1ns/100ps
module msp_port_checker
  import msp_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Processor side.
  input wire logic new_variant,
  input wire logic cpu_req,
  input wire logic cpu_ce3,
  input wire logic cpu_we,
  input wire logic [MSP_HAW-1:0] cpu_addr,
  input wire logic cpu_ack,
  // Module pins.
  input wire logic [MSP_AW-1:0] module_addr,
  input wire logic [MSP_DW-1:0] module_data_out,
  input wire logic module_data_oe_n,
  input wire logic module_xfer_strobe_n,
  input wire logic module_write_en_n,
  input wire logic module_ready_n,
  // Resets and interrupts.
  input wire logic site_reset_bit,
  input wire logic site_reset_n,
  input wire logic dedicated_module_irq1_n,
  input wire logic [MSP_NIRQ-1:0] irq_enable,
  input wire logic [3*MSP_NIRQ-1:0] irq_route,
  input wire logic [MSP_NTGT-1:0] cpu_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // A transfer starts where the strobe falls and runs while it stays low.
  sequence s_start;
    $fell(module_xfer_strobe_n);
  endsequence
  sequence s_held;
    !module_xfer_strobe_n && $past(!module_xfer_strobe_n);
  endsequence
  a_strobe_in_range: assert property (s_start |-> $past(cpu_req && cpu_ce3
    && (cpu_addr & MSP_SUB_MASK) == MSP_SUB_BASE)) else $error("strobe out of range");
  a_addr_mapped: assert property (s_start |-> module_addr == ($past(new_variant)
    ? $past(cpu_addr[6:1]) : $past(cpu_addr[7:2]))) else $error("address map wrong");
  a_write_marked: assert property (s_start |-> module_write_en_n == !$past(cpu_we))
    else $error("write enable wrong");
  a_drive_on_write: assert property (!module_xfer_strobe_n
    |-> module_data_oe_n == module_write_en_n) else $error("data drive wrong");
  a_start_released: assert property (s_start |-> $past(module_ready_n, 3))
    else $error("stale ready");
  a_outputs_held: assert property (s_held |-> $stable(module_addr)
    && $stable(module_write_en_n) && $stable(module_data_out)) else $error("outputs moved");
  a_ack_after_ready: assert property (cpu_ack
    |-> !module_ready_n && $past(!module_ready_n, 2)) else $error("ack without ready");
  a_site_follows_bit: assert property ($past(resetn) && $past(clk_en)
    |-> site_reset_n == !$past(site_reset_bit)) else $error("site reset wrong");
  a_irq_on_fall: assert property ($fell(dedicated_module_irq1_n) && irq_enable[1]
    && irq_route[5:3] < 3'h5 |-> ##3 cpu_irq[irq_route[5:3]]) else $error("irq missed");
  a_irq_one_pulse: assert property (cpu_irq != 5'h00 |=> cpu_irq == 5'h00)
    else $error("irq repeated");
endmodule

bind msp_port msp_port_checker chk_i (.*);

/* testbench/testbench.sv */
// Self-checking bench for the module site parallel port.
`timescale 1ns/100ps
module testbench;
  import msp_pkg::*;
  logic clk, resetn, clk_en, new_variant, cpu_req, cpu_ce3, cpu_we, cpu_ack, cpu_busy;
  logic [MSP_HAW-1:0] cpu_addr;
  logic [MSP_DW-1:0] cpu_wdata, cpu_rdata, module_data_in, module_data_out;
  logic [MSP_AW-1:0] module_addr;
  logic module_data_oe_n, module_xfer_strobe_n, module_write_en_n, module_ready_n;
  logic site_reset_bit, extender_reset_bit, site_reset_n, extender_reset_n, cpu_ext_irq4;
  logic dedicated_module_irq0_n, dedicated_module_irq1_n, dedicated_module_irq2_n;
  logic pio_site_irq0_n;
  logic [MSP_NIRQ-1:0] irq_enable;
  logic [3*MSP_NIRQ-1:0] irq_route;
  logic [MSP_NTGT-1:0] cpu_irq;
  logic [3:0] wait_cycles, pins_n;
  logic [MSP_DW-1:0] ref_mem [64]; // Expected module memory.
  int failures, tests_run;
  // Request pins idle high and are pulled low one at a time.
  assign {pio_site_irq0_n, dedicated_module_irq2_n} = pins_n[3:2];
  assign {dedicated_module_irq1_n, dedicated_module_irq0_n} = pins_n[1:0];
  msp_port uut (.*);
  msp_module_model partner (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Module address that a processor byte address selects on each variant.
  function automatic logic [5:0] map_addr(input logic nv, input logic [31:0] a);
    return nv ? a[6:1] : a[7:2];
  endfunction
  // Target pulses expected for one falling request on pin src.
  function automatic logic [4:0] exp_irq(input int src, input logic nv, input logic en,
      input logic [2:0] rt);
    logic [4:0] e;
    e = (en && rt < 3'h5) ? 5'h01 << rt : 5'h00;
    if (!nv && (src == 0 || src == 3)) e = {4'h0, en};
    if (nv && src == 3) e = 5'h00;
    return e;
  endfunction
  // One byte transfer; a miss is dropped after a bounded wait.
  task automatic xfer(input logic ce, input logic we, input logic [31:0] a, input logic [7:0] d);
    logic hit;
    logic [5:0] ma;
    int n;
    hit = ce && (a & MSP_SUB_MASK) == MSP_SUB_BASE;
    @(posedge clk);
    ma = map_addr(new_variant, a);
    cpu_req <= 1'b1;
    cpu_ce3 <= ce;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= d;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cpu_ack !== 1'b1 && n < 40);
    chk("ack", cpu_ack, hit);
    chk("busy", cpu_busy, hit);
    if (hit && !we) chk("rdata", cpu_rdata, ref_mem[ma]);
    if (hit && we) ref_mem[ma] = d;
    @(posedge clk);
    cpu_req <= 1'b0;
  endtask
  // Pulse one request pin low for six cycles and collect the outputs.
  task automatic irq_try(input int src, input logic nv, input logic en, input logic [2:0] rt);
    logic [4:0] seen, exp;
    logic seen4;
    int pulses;
    @(posedge clk);
    new_variant <= nv;
    irq_enable <= {3{en}};
    irq_route <= {3{rt}};
    exp = exp_irq(src, nv, en, rt);
    seen = 5'h00;
    seen4 = 1'b0;
    pulses = 0;
    for (int k = 0; k < 14; k++) begin
      @(posedge clk);
      if (k == 2) pins_n[src] <= 1'b0;
      if (k == 8) pins_n[src] <= 1'b1;
      #1;
      seen |= cpu_irq;
      seen4 |= cpu_ext_irq4;
      pulses += int'(cpu_irq != 5'h00);
    end
    chk("irq_target", seen, exp);
    chk("ext_irq4", seen4, exp[0]);
    chk("irq_pulses", pulses, exp != 5'h00);
  endtask
  initial begin
    void'($urandom(32'h5bb9eb11));
    for (int i = 0; i < 64; i++) ref_mem[i] = 8'(i) ^ 8'h3C;
    {resetn, cpu_req, cpu_ce3, cpu_we, new_variant, site_reset_bit, extender_reset_bit} = 7'h00;
    clk_en = 1'b1;
    cpu_addr = 32'h0;
    cpu_wdata = 8'h00;
    irq_enable = 3'h0;
    irq_route = 9'h000;
    wait_cycles = 4'hC;
    pins_n = 4'hF;
    failures = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      site_reset_bit <= i[0];
      extender_reset_bit <= i[1];
      repeat (2) @(posedge clk);
      #1;
      chk("site_reset", site_reset_n, !i[0]);
      chk("ext_reset", extender_reset_n, !i[1]);
    end
    // Clock enable low freezes the reset pin even though its bit moves.
    @(posedge clk);
    clk_en <= 1'b0;
    site_reset_bit <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("site_frozen", site_reset_n, 1'b0);
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("site_thawed", site_reset_n, 1'b1);
    // Top of the range with a slow module, then the first byte past it.
    xfer(1'b1, 1'b1, 32'hFF, 8'hC3);
    xfer(1'b1, 1'b0, 32'hFF, 8'h00);
    xfer(1'b1, 1'b1, 32'h100, 8'h11);
    for (int i = 0; i < 150; i++) begin
      logic [31:0] a;
      a = {24'h0, 8'($urandom)};
      if ($urandom_range(0, 7) == 0) a[31:8] = 24'($urandom | 1);
      new_variant <= 1'($urandom);
      wait_cycles <= 4'($urandom_range(0, 9));
      xfer(1'($urandom_range(0, 9) != 0), 1'($urandom), a, 8'($urandom));
    end
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 9; r++) begin
        irq_try(s, 1'b0, r < 8, 3'(r));
        irq_try(s, 1'b1, r < 8, 3'(r));
      end
    end
    tally_and_finish();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule
